//--- common/cvd_pkg.sv
`default_nettype none
package cvd_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int RAW_W = 12;
  localparam int RES_W = 16;
  localparam int CAP_W = 5;
  localparam int DIV_W = 6;
  localparam logic [ADDR_W-1:0] OFS_CTRL_MAIN = 16'h1d26;
  localparam logic [ADDR_W-1:0] OFS_CTRL_CVD = 16'h1d27;
  localparam logic [ADDR_W-1:0] OFS_CTRL_THR = 16'h1d29;
  localparam logic [ADDR_W-1:0] OFS_ACQ = 16'h1d30;
  localparam logic [ADDR_W-1:0] OFS_PRE = 16'h1d31;
  localparam logic [ADDR_W-1:0] OFS_CAP = 16'h1d32;
  localparam logic [ADDR_W-1:0] OFS_CLKDIV = 16'h1d33;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 16'h1d34;
  localparam logic [ADDR_W-1:0] OFS_RES_LO = 16'h1d35;
  localparam logic [ADDR_W-1:0] OFS_RES_HI = 16'h1d36;
  localparam logic [ADDR_W-1:0] OFS_PREV_LO = 16'h1d37;
  localparam logic [ADDR_W-1:0] OFS_PREV_HI = 16'h1d38;
  localparam int B_ON = 7;
  localparam int B_CONTINUOUS_RETRIGGER = 6;
  localparam int B_CS = 4;
  localparam int B_FM_HI = 3;
  localparam int B_FM_LO = 2;
  localparam int B_IC = 1;
  localparam int B_GO = 0;
  localparam int B_INV = 6;
  localparam int B_GUARD_START_POLARITY = 5;
  localparam int B_DOUBLE_SAMPLE_ENABLE = 0;
  localparam int B_SOI = 3;
  localparam int B_DONE = 0;
  localparam int B_THR = 1;
  localparam int B_BUSY = 2;
  localparam logic [DATA_W-1:0] MAIN_RST = 8'h02;
  localparam logic [DATA_W-1:0] MAIN_MASK = 8'hdf;
  localparam logic [DATA_W-1:0] CVD_MASK = 8'h61;
  localparam logic [DATA_W-1:0] THR_MASK = 8'h08;
  localparam logic [7:0] CONV_TICKS = 8'h0e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE = 2'b01,
    ST_ACQ = 2'b10,
    ST_CONV = 2'b11
  } cvd_state_e;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } cvd_bus_req_s;
  typedef struct packed {
    logic a;
    logic b;
  } cvd_guard_s;
endpackage
`default_nettype wire

//--- hdl/cvd_acquisition_guard_control.sv
// Operation
// - Acquisition follows precharge at once, timed by the acquisition count.
// - Acquisition turns pin drivers off and links channel to hold capacitor.
// - With precharge on, acquisition count zero gives the longest acquisition.
// - With precharge off, acquisition count zero removes acquisition timing.
// - Two guard outputs A and B leave the block for pin routing.
// - First precharge start drives both guards to the start polarity.
// - Acquisition start inverts guard A, keeps guard B.
// - Double sample with invert: second precharge inverts both, A toggles again.
// - Extra hold capacitance is connected, except during conversion.
// - Enable bit 7 gates the converter; start needs it set.
// - Continuous mode relaunches until threshold stop or software clear.
// - Without continuous mode, start/busy clears at each completion.
// - Clock source bit picks RC oscillator or divided system clock.
// - Single-ended format low bit picks right or left justified.
// - Differential format picks sign-magnitude or two's complement, justified.
// - Input configuration bit picks differential when one; resets to one.
// - Writing start sets busy; busy reads one until the cycle ends.
// - Software abort stores partial result, resets, no done flag.
// - Precharge runs when its count is nonzero, skipped when zero.
// - Start polarity one makes guards start high, zero low.
// - Invert bit has effect only with double sampling.
`timescale 1ns/100ps
`default_nettype none
module cvd_acquisition_guard_control
  import cvd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire cvd_bus_req_s busReq,
  output logic [DATA_W-1:0] rdData,
  input wire logic rcOscIn,
  input wire logic [RAW_W-1:0] convData,
  input wire logic thrEvent,
  output cvd_guard_s guardOut,
  output logic pinDriversOff,
  output logic holdConnect,
  output logic [CAP_W-1:0] extraCapSel,
  output logic convActive,
  output logic convClkRc
);

  function automatic logic [RES_W-1:0] fmtResult(
    input logic [RAW_W-1:0] raw,
    input logic [1:0] fm,
    input logic ic
  );
    logic [RAW_W-1:0] mag;
    logic [RES_W-RAW_W-1:0] pad;
    pad = '0;
    mag = raw[RAW_W-1] ? RAW_W'(-raw) : raw;
    if (!ic) begin
      fmtResult = fm[0] ? {pad, raw} : {raw, pad};
    end else begin
      unique case (fm)
        2'b11: fmtResult = {raw[RAW_W-1], pad[2:0], mag};
        2'b10: fmtResult = {raw[RAW_W-1], mag[RAW_W-2:0], pad};
        2'b01: fmtResult = {{(RES_W-RAW_W){raw[RAW_W-1]}}, raw};
        2'b00: fmtResult = {raw, pad};
      endcase
    end
  endfunction

  logic [DATA_W-1:0] mainReg;
  logic [DATA_W-1:0] cvdReg;
  logic [DATA_W-1:0] thrCtlReg;
  logic [7:0] acqReg;
  logic [7:0] preReg;
  logic [CAP_W-1:0] capReg;
  logic [DIV_W-1:0] divReg;
  logic doneReg;
  logic thrReg;
  logic [RES_W-1:0] resReg;
  logic [RES_W-1:0] prevReg;
  cvd_state_e stReg;
  cvd_state_e stNext;
  logic [7:0] cntReg;
  logic [7:0] cntNext;
  logic sampleIdxReg;
  logic [DIV_W-1:0] divCntReg;
  logic rcS1Reg;
  logic rcS2Reg;
  logic rcS3Reg;
  logic tick;
  logic enterPre;
  logic enterAcq;
  logic complete;
  logic abort;
  logic acqTimed;
  logic wrMain;
  logic thrStop;

  assign wrMain = busReq.wr && busReq.addr == OFS_CTRL_MAIN;
  // Abort on software clear of busy, or when enable drops mid-cycle
  assign abort = stReg != ST_IDLE &&
    ((wrMain && !busReq.wdata[B_GO]) || !mainReg[B_ON]);
  assign acqTimed = acqReg != 8'h00 || preReg != 8'h00;
  assign thrStop = thrCtlReg[B_SOI] && (thrReg || thrEvent);

  // RC oscillator is foreign to ref_clk; stage 1 feeds only stage 2
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rcS1Reg <= 1'b0;
      rcS2Reg <= 1'b0;
      rcS3Reg <= 1'b0;
    end else begin
      rcS1Reg <= rcOscIn;
      rcS2Reg <= rcS1Reg;
      rcS3Reg <= rcS2Reg;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      divCntReg <= '0;
    end else if (divCntReg >= divReg) begin
      divCntReg <= '0;
    end else begin
      divCntReg <= DIV_W'(divCntReg + 1'b1);
    end
  end

  // Converter clock period: RC edge or divided ref_clk
  assign tick = mainReg[B_CS] ? (rcS2Reg && !rcS3Reg)
                              : (divCntReg >= divReg);

  always_comb begin
    stNext = stReg;
    cntNext = cntReg;
    enterPre = 1'b0;
    enterAcq = 1'b0;
    complete = 1'b0;
    unique case (stReg)
      ST_IDLE: begin
        if (mainReg[B_GO] && mainReg[B_ON]) begin
          if (preReg != 8'h00) begin
            stNext = ST_PRE;
            cntNext = preReg;
            enterPre = 1'b1;
          end else begin
            enterAcq = 1'b1;
            stNext = acqTimed ? ST_ACQ : ST_CONV;
            cntNext = acqTimed ? acqReg : CONV_TICKS;
          end
        end
      end
      ST_PRE: begin
        if (tick) begin
          if (cntReg == 8'h01) begin
            enterAcq = 1'b1;
            stNext = ST_ACQ;
            cntNext = acqReg; // Zero wraps to the full 256 periods
          end else begin
            cntNext = 8'(cntReg - 1'b1);
          end
        end
      end
      ST_ACQ: begin
        if (tick) begin
          if (cntReg == 8'h01) begin
            stNext = ST_CONV;
            cntNext = CONV_TICKS;
          end else begin
            cntNext = 8'(cntReg - 1'b1);
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          if (cntReg == 8'h01) begin
            complete = 1'b1;
            stNext = ST_IDLE;
          end else begin
            cntNext = 8'(cntReg - 1'b1);
          end
        end
      end
    endcase
    if (abort) begin
      stNext = ST_IDLE;
      cntNext = 8'h00;
      enterPre = 1'b0;
      enterAcq = 1'b0;
      complete = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stReg <= ST_IDLE;
      cntReg <= 8'h00;
    end else begin
      stReg <= stNext;
      cntReg <= cntNext;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sampleIdxReg <= 1'b0;
    end else if (abort) begin
      sampleIdxReg <= 1'b0;
    end else if (complete) begin
      sampleIdxReg <= cvdReg[B_DOUBLE_SAMPLE_ENABLE] && !sampleIdxReg;
    end
  end

  // Guards only move on stage entries, otherwise they hold
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      guardOut <= '0;
    end else if (enterPre) begin
      if (sampleIdxReg && cvdReg[B_DOUBLE_SAMPLE_ENABLE] && cvdReg[B_INV]) begin
        guardOut.a <= !cvdReg[B_GUARD_START_POLARITY];
        guardOut.b <= !cvdReg[B_GUARD_START_POLARITY];
      end else begin
        guardOut.a <= cvdReg[B_GUARD_START_POLARITY];
        guardOut.b <= cvdReg[B_GUARD_START_POLARITY];
      end
    end else if (enterAcq) begin
      guardOut.a <= !guardOut.a;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pinDriversOff <= 1'b0;
      holdConnect <= 1'b0;
      extraCapSel <= '0;
      convActive <= 1'b0;
      convClkRc <= 1'b0;
    end else begin
      pinDriversOff <= stNext == ST_ACQ;
      holdConnect <= stNext == ST_ACQ;
      extraCapSel <= (stNext == ST_CONV) ? '0 : capReg;
      convActive <= stNext == ST_CONV;
      convClkRc <= mainReg[B_CS];
    end
  end

  // Start/busy: a software write beats a same-cycle hardware clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mainReg <= MAIN_RST;
    end else if (wrMain) begin
      mainReg <= busReq.wdata & MAIN_MASK;
      mainReg[B_GO] <= busReq.wdata[B_GO] && busReq.wdata[B_ON];
    end else if (!mainReg[B_ON]) begin
      mainReg[B_GO] <= 1'b0;
    end else if (complete) begin
      if (!mainReg[B_CONTINUOUS_RETRIGGER] || thrStop) begin
        mainReg[B_GO] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cvdReg <= '0;
      thrCtlReg <= '0;
      acqReg <= 8'h00;
      preReg <= 8'h00;
      capReg <= '0;
      divReg <= '0;
    end else if (busReq.wr) begin
      unique case (busReq.addr)
        OFS_CTRL_CVD: cvdReg <= busReq.wdata & CVD_MASK;
        OFS_CTRL_THR: thrCtlReg <= busReq.wdata & THR_MASK;
        OFS_ACQ: acqReg <= busReq.wdata;
        OFS_PRE: preReg <= busReq.wdata;
        OFS_CAP: capReg <= busReq.wdata[CAP_W-1:0];
        OFS_CLKDIV: divReg <= busReq.wdata[DIV_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky flags: write one clears, a same-cycle event wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      doneReg <= 1'b0;
      thrReg <= 1'b0;
    end else begin
      if (complete) begin
        doneReg <= 1'b1;
      end else if (busReq.wr && busReq.addr == OFS_STATUS &&
                   busReq.wdata[B_DONE]) begin
        doneReg <= 1'b0;
      end
      if (thrEvent) begin
        thrReg <= 1'b1;
      end else if (busReq.wr && busReq.addr == OFS_STATUS &&
                   busReq.wdata[B_THR]) begin
        thrReg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      resReg <= '0;
      prevReg <= '0;
    end else if (complete || abort) begin
      prevReg <= resReg;
      resReg <= fmtResult(convData, mainReg[B_FM_HI:B_FM_LO], mainReg[B_IC]);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= '0;
    end else if (busReq.rd) begin
      unique case (busReq.addr)
        OFS_CTRL_MAIN: rdData <= mainReg;
        OFS_CTRL_CVD: rdData <= cvdReg;
        OFS_CTRL_THR: rdData <= thrCtlReg;
        OFS_ACQ: rdData <= acqReg;
        OFS_PRE: rdData <= preReg;
        OFS_CAP: rdData <= DATA_W'(capReg);
        OFS_CLKDIV: rdData <= DATA_W'(divReg);
        OFS_STATUS: rdData <= DATA_W'({stReg != ST_IDLE, thrReg, doneReg});
        OFS_RES_LO: rdData <= resReg[7:0];
        OFS_RES_HI: rdData <= resReg[15:8];
        OFS_PREV_LO: rdData <= prevReg[7:0];
        OFS_PREV_HI: rdData <= prevReg[15:8];
        default: rdData <= '0;
      endcase
    end else begin
      rdData <= '0;
    end
  end

endmodule
`default_nettype wire

//--- test/cvd_acquisition_guard_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin totalChecks++; if ((g) !== (e)) begin \
  fails++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module cvd_acquisition_guard_control_bench;
  import cvd_pkg::*;
  localparam logic [RAW_W-1:0] SENSE = 12'h5a3;
  logic refClk = 1'b0;
  logic arstN = 1'b0;
  cvd_bus_req_s busReq = '0;
  logic thrEvent = 1'b0;
  // Slow free-running RC source, edges on falling ref_clk to avoid races
  logic rcOsc = 1'b0;
  logic [DATA_W-1:0] rdData, v;
  logic [RES_W-1:0] r;
  logic [RAW_W-1:0] convData;
  cvd_guard_s guardOut;
  logic pinDriversOff, holdConnect, convActive, convClkRc;
  logic [CAP_W-1:0] extraCapSel;
  int fails = 0;
  int totalChecks = 0;
  always #10 refClk = ~refClk;
  always #80 rcOsc = ~rcOsc;
  cvd_acquisition_guard_control DUT (
    .ref_clk(refClk),
    .arst_n(arstN),
    .busReq(busReq),
    .rdData(rdData),
    .rcOscIn(rcOsc),
    .convData(convData),
    .thrEvent(thrEvent),
    .guardOut(guardOut),
    .pinDriversOff(pinDriversOff),
    .holdConnect(holdConnect),
    .extraCapSel(extraCapSel),
    .convActive(convActive),
    .convClkRc(convClkRc)
  );
  cvd_sensor_model #(.SENSE(SENSE)) sensor (
    .ref_clk(refClk),
    .arst_n(arstN),
    .guardOut(guardOut),
    .holdConnect(holdConnect),
    .convActive(convActive),
    .convData(convData)
  );
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge refClk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge refClk);
    busReq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge refClk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge refClk);
    busReq.rd <= 1'b0;
    #1 d = rdData;
  endtask
  // Polls busy; a stuck conversion is reported, not waited on forever
  task automatic waitIdle();
    for (int i = 0; i < 300; i++) begin
      rd(OFS_CTRL_MAIN, v);
      if (v[B_GO] === 1'b0) return;
    end
    fails++;
    $display("[ERR] busy stuck");
  endtask
  task automatic chkRes(input logic [RES_W-1:0] e);
    rd(OFS_RES_LO, r[7:0]);
    rd(OFS_RES_HI, r[15:8]);
    `CHK("result", e, r)
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    $display("[ERR] timeout");
    conclude();
  end
  initial begin
    repeat (12) @(posedge refClk);
    arstN <= 1'b1;
    rd(OFS_CTRL_MAIN, v);
    `CHK("main reset", 8'h02, v)
    rd(16'h1d3f, v);
    `CHK("unmapped", 8'h00, v)
    wr(OFS_PRE, 8'h02);
    wr(OFS_ACQ, 8'h03);
    wr(OFS_CLKDIV, 8'h00);
    wr(OFS_CAP, 8'h1f);
    wr(OFS_CTRL_CVD, 8'h20);
    wr(OFS_CTRL_MAIN, 8'h11);
    rd(OFS_CTRL_MAIN, v);
    `CHK("go without on", 8'h10, v)
    for (int f = 0; f < 2; f++) begin
      wr(OFS_CTRL_MAIN, 8'h81 | 8'(f << 2));
      rd(OFS_CTRL_MAIN, v);
      `CHK("busy", 1'b1, v[B_GO])
      waitIdle();
      rd(OFS_STATUS, v);
      `CHK("done", 1'b1, v[B_DONE])
      wr(OFS_STATUS, 8'h01);
      chkRes(f ? {4'h0, ~SENSE} : {~SENSE, 4'h0});
      `CHK("guards", 2'b01, guardOut)
      `CHK("cap idle", 5'h1f, extraCapSel)
    end
    wr(OFS_CTRL_MAIN, 8'h81);
    repeat (14) @(posedge refClk);
    wr(OFS_CTRL_MAIN, 8'h80);
    rd(OFS_STATUS, v);
    `CHK("abort done", 1'b0, v[B_DONE])
    chkRes({~SENSE, 4'h0});
    wr(OFS_CTRL_THR, 8'h08);
    wr(OFS_CTRL_MAIN, 8'hc1);
    repeat (60) @(posedge refClk);
    rd(OFS_CTRL_MAIN, v);
    `CHK("retrigger", 1'b1, v[B_GO])
    @(posedge refClk);
    thrEvent <= 1'b1;
    @(posedge refClk);
    thrEvent <= 1'b0;
    waitIdle();
    rd(OFS_STATUS, v);
    `CHK("threshold", 1'b1, v[B_THR])
    wr(OFS_CTRL_THR, 8'h00);
    wr(OFS_CTRL_CVD, 8'h61);
    wr(OFS_CTRL_MAIN, 8'h81);
    waitIdle();
    `CHK("first guards", 2'b01, guardOut)
    wr(OFS_CTRL_MAIN, 8'h81);
    waitIdle();
    `CHK("second guards", 2'b10, guardOut)
    wr(OFS_PRE, 8'h00);
    wr(OFS_ACQ, 8'h00);
    wr(OFS_STATUS, 8'h01);
    wr(OFS_CTRL_MAIN, 8'h91);
    waitIdle();
    rd(OFS_STATUS, v);
    `CHK("rc done", 1'b1, v[B_DONE])
    `CHK("rc source", 1'b1, convClkRc)
    conclude();
  end
endmodule
`default_nettype wire

//--- test/cvd_agc_sva.sv
`timescale 1ns/100ps
`default_nettype none
module cvd_agc_sva
  import cvd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire cvd_bus_req_s busReq,
  input wire logic [DATA_W-1:0] rdData,
  input wire logic rcOscIn,
  input wire logic [RAW_W-1:0] convData,
  input wire logic thrEvent,
  input wire cvd_guard_s guardOut,
  input wire logic pinDriversOff,
  input wire logic holdConnect,
  input wire logic [CAP_W-1:0] extraCapSel,
  input wire logic convActive,
  input wire logic convClkRc
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_capOff;
    convActive |-> extraCapSel == '0;
  endproperty
  a_capOff: assert property (p_capOff)
    else $error("extra capacitance connected in conversion");
  property p_acqPins;
    pinDriversOff |-> holdConnect && !convActive;
  endproperty
  a_acqPins: assert property (p_acqPins)
    else $error("pin override without hold link");
  property p_guardFlip;
    $rose(holdConnect) |-> guardOut.a != $past(guardOut.a)
      && guardOut.b == $past(guardOut.b);
  endproperty
  a_guardFlip: assert property (p_guardFlip)
    else $error("guard A not flipped at acquisition");
  property p_convHold;
    convActive && $past(convActive) |-> $stable(guardOut);
  endproperty
  a_convHold: assert property (p_convHold)
    else $error("guards moved during conversion");
  // Two cycles cover both a direct and a re-registered copy
  property p_clkSel;
    busReq.wr && busReq.addr == OFS_CTRL_MAIN
      |-> ##2 convClkRc == $past(busReq.wdata[B_CS], 2);
  endproperty
  a_clkSel: assert property (p_clkSel)
    else $error("clock source copy wrong");
  property p_goNeedsOn;
    busReq.rd && busReq.addr == OFS_CTRL_MAIN
      |=> !rdData[B_GO] || rdData[B_ON];
  endproperty
  a_goNeedsOn: assert property (p_goNeedsOn)
    else $error("busy set while disabled");
  property p_acqToConv;
    $fell(pinDriversOff) |-> convActive;
  endproperty
  a_acqToConv: assert property (p_acqToConv)
    else $error("acquisition not followed by conversion");
  property p_convLen;
    $rose(convActive) |-> convActive [*8];
  endproperty
  a_convLen: assert property (p_convLen)
    else $error("conversion stage too short");
endmodule
bind cvd_acquisition_guard_control cvd_agc_sva u_sva (
  .ref_clk(ref_clk),
  .arst_n(arst_n),
  .busReq(busReq),
  .rdData(rdData),
  .rcOscIn(rcOscIn),
  .convData(convData),
  .thrEvent(thrEvent),
  .guardOut(guardOut),
  .pinDriversOff(pinDriversOff),
  .holdConnect(holdConnect),
  .extraCapSel(extraCapSel),
  .convActive(convActive),
  .convClkRc(convClkRc)
);
`default_nettype wire

//--- test/cvd_sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
module cvd_sensor_model
  import cvd_pkg::*;
#(
  parameter logic [RAW_W-1:0] SENSE = 12'h5a3
)(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire cvd_guard_s guardOut,
  input wire logic holdConnect,
  input wire logic convActive,
  output logic [RAW_W-1:0] convData
);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      convData <= '0;
    end else if (holdConnect) begin
      // Divider level follows the guard phase seen by the sensor
      convData <= guardOut.a ? SENSE : ~SENSE;
    end else if (!convActive) begin
      // Floating node: no stale sample survives between frames
      convData <= ~convData;
    end
  end
endmodule
`default_nettype wire
